// [src/asrs_top.sv]
// Alarm status register set: live state, latched events and summary mask
// How it works
// - Live state register is read-only; querying it changes nothing.
// - Clear-status empties the alarm queue and clears the queue-not-empty bit.
// - Bit 4 is set while the alarm queue holds any entry.
// - Numbered alarms one to four map to bits 6 through 9.
// - Bit 12 is set when a lower-limit alarm has occurred.
// - Bit 13 is set when an upper-limit alarm has occurred.
// - Every query returns the weighted sum of set bits, an unsigned integer.
// - Mask register accepts a 16-bit value but stores and returns only the used bits, 33d0 hex.
// - Latched events enabled by the mask feed the status byte summary.
// - Preset clears the summary mask to zero.
// - Latched event bits stay set until queried or clear-status.
module asrs_top (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // Command port
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_code_i,
    input wire logic [15:0] cmd_data_i,
    output logic resp_valid_o,
    output logic [15:0] resp_data_o,
    // Alarm sources
    input wire logic queue_push_i,
    input wire logic queue_pop_i,
    input wire logic [3:0] alarm_i,
    input wire logic lower_limit_i,
    input wire logic upper_limit_i,
    // Status outputs
    output logic queue_full_o,
    output logic alarm_summary_o
);

    logic [15:0] live_state;
    logic [15:0] live_prev_q;
    logic [15:0] rise;
    logic [15:0] alarm_latched_events_q;
    logic [15:0] alarm_summary_mask_q;
    logic queue_not_empty;
    logic clear_status;
    logic preset;
    logic events_query;
    logic live_query;
    logic mask_write;
    logic mask_query;
    logic summary_q;

    // Keeps only the documented bits, so unused positions never leak out
    function automatic logic [15:0] used_bits(input logic [15:0] v);
        used_bits = v & asrs_pkg::USED_MASK;
    endfunction

    // Matches a command code against the valid strobe; the strobe is an argument
    // So a continuous assignment re-evaluates when the strobe drops under a held code
    function automatic logic is_cmd(input logic valid, input logic [2:0] code,
                                    input asrs_pkg::asrs_cmd_e c);
        is_cmd = valid && (code == 3'(c));
    endfunction

    // Command decode
    assign live_query = is_cmd(cmd_valid_i, cmd_code_i, asrs_pkg::ASRS_CMD_LIVE_QUERY);
    assign events_query = is_cmd(cmd_valid_i, cmd_code_i, asrs_pkg::ASRS_CMD_EVENTS_QUERY);
    assign mask_write = is_cmd(cmd_valid_i, cmd_code_i, asrs_pkg::ASRS_CMD_MASK_WRITE);
    assign mask_query = is_cmd(cmd_valid_i, cmd_code_i, asrs_pkg::ASRS_CMD_MASK_QUERY);
    assign preset = is_cmd(cmd_valid_i, cmd_code_i, asrs_pkg::ASRS_CMD_PRESET);
    assign clear_status = is_cmd(cmd_valid_i, cmd_code_i, asrs_pkg::ASRS_CMD_CLEAR_STATUS);

    // Alarm queue occupancy; clear-status flushes it
    asrs_queue_count u_queue (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .push_i(queue_push_i),
        .pop_i(queue_pop_i),
        .flush_i(clear_status),
        .not_empty_o(queue_not_empty),
        .full_o(queue_full_o)
    );

    // Live condition word assembled from the sources
    always_comb begin
        live_state = '0;
        live_state[asrs_pkg::BIT_QUEUE] = queue_not_empty;
        live_state[asrs_pkg::BIT_ALARM_HI:asrs_pkg::BIT_ALARM_LO] = alarm_i;
        live_state[asrs_pkg::BIT_LOWER] = lower_limit_i;
        live_state[asrs_pkg::BIT_UPPER] = upper_limit_i;
        live_state = used_bits(live_state);
    end

    // Previous live word, for rising-edge detection of conditions
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            live_prev_q <= '0;
        end else if (clk_en_i) begin
            live_prev_q <= live_state;
        end
    end

    assign rise = live_state & ~live_prev_q;

    // Latch rising conditions; a rise in the clearing cycle survives the clear
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            alarm_latched_events_q <= asrs_pkg::EVENTS_RESET;
        end else if (clk_en_i) begin
            if (events_query || clear_status) begin
                alarm_latched_events_q <= rise;
            end else begin
                alarm_latched_events_q <= alarm_latched_events_q | rise;
            end
        end
    end

    // Summary mask; preset zeroes it, a write keeps only the bits in USED_MASK
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            alarm_summary_mask_q <= asrs_pkg::MASK_RESET;
        end else if (clk_en_i) begin
            if (preset) begin
                alarm_summary_mask_q <= asrs_pkg::PRESET_VALUE;
            end else if (mask_write) begin
                alarm_summary_mask_q <= used_bits(cmd_data_i);
            end
        end
    end

    // Summary bit toward the status byte register
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            summary_q <= 1'b0;
        end else if (clk_en_i) begin
            summary_q <= |(alarm_latched_events_q & alarm_summary_mask_q);
        end
    end

    assign alarm_summary_o = summary_q;

    // Query answers, one cycle after the command; reads of live state are pure
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            resp_valid_o <= 1'b0;
            resp_data_o <= '0;
        end else if (clk_en_i) begin
            resp_valid_o <= live_query || events_query || mask_query;
            if (live_query) begin
                resp_data_o <= live_state;
            end else if (events_query) begin
                resp_data_o <= used_bits(alarm_latched_events_q);
            end else if (mask_query) begin
                resp_data_o <= alarm_summary_mask_q;
            end
        end
    end

endmodule // asrs_top

// [src/asrs_pkg.sv]
// Package of constants for the alarm status register set
package asrs_pkg;

    // Alarm register bit positions
    localparam int unsigned BIT_QUEUE = 4;
    localparam int unsigned BIT_ALARM_LO = 6;
    localparam int unsigned BIT_ALARM_HI = 9;
    localparam int unsigned BIT_LOWER = 12;
    localparam int unsigned BIT_UPPER = 13;
    localparam int unsigned NUM_ALARMS = 4;
    localparam int unsigned REG_W = 16;

    // Bits that can ever be one; all others read as zero
    localparam logic [15:0] USED_MASK = 16'h33d0;

    // Reset values
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] EVENTS_RESET = 16'h0000;
    localparam logic [15:0] PRESET_VALUE = 16'h0000;

    // Alarm queue depth
    localparam int unsigned QUEUE_DEPTH = 16;
    localparam int unsigned QUEUE_CNT_W = 5;

    // Command codes on the command port
    typedef enum logic [2:0] {
        ASRS_CMD_NONE,
        ASRS_CMD_LIVE_QUERY,
        ASRS_CMD_EVENTS_QUERY,
        ASRS_CMD_MASK_WRITE,
        ASRS_CMD_MASK_QUERY,
        ASRS_CMD_PRESET,
        ASRS_CMD_CLEAR_STATUS
    } asrs_cmd_e;

endpackage : asrs_pkg

// [src/asrs_queue_count.sv]
// Occupancy counter of the alarm queue
module asrs_queue_count (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic flush_i,
    output logic not_empty_o,
    output logic full_o
);

    logic [asrs_pkg::QUEUE_CNT_W-1:0] count_q;

    // Flush wins over push and pop; a full queue drops further entries
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            count_q <= '0;
        end else if (clk_en_i) begin
            if (flush_i) begin
                count_q <= '0;
            end else if (push_i && !full_o && !(pop_i && not_empty_o)) begin
                count_q <= count_q + 1'b1;
            end else if (pop_i && not_empty_o && !push_i) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    assign not_empty_o = (count_q != '0);
    assign full_o = (count_q == asrs_pkg::QUEUE_CNT_W'(asrs_pkg::QUEUE_DEPTH));

endmodule // asrs_queue_count

// [tb/asrs_assertions.sv]
// Port checker for the alarm status register set
module asrs_checker (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_code_i,
    input wire logic [15:0] cmd_data_i,
    input wire logic resp_valid_o,
    input wire logic [15:0] resp_data_o,
    input wire logic queue_push_i,
    input wire logic queue_pop_i,
    input wire logic [3:0] alarm_i,
    input wire logic lower_limit_i,
    input wire logic upper_limit_i,
    input wire logic alarm_summary_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_cmd(c);
        cmd_valid_i && clk_en_i && cmd_code_i == c;
    endsequence
    // Quiet query: no source moved since last cycle, so no new rise can land
    sequence s_q(c);
        cmd_valid_i && clk_en_i && cmd_code_i == c && !queue_push_i && !queue_pop_i &&
            $stable({alarm_i, lower_limit_i, upper_limit_i, queue_push_i, queue_pop_i});
    endsequence
    a_answer_strobe: assert property (clk_en_i |=>
        resp_valid_o == $past(cmd_valid_i && cmd_code_i inside {3'h1, 3'h2, 3'h4}))
        else $error("answer strobe wrong");
    a_answer_hold: assert property (!resp_valid_o |-> $stable(resp_data_o))
        else $error("answer changed without strobe");
    a_unused_zero: assert property ((resp_data_o & ~asrs_pkg::USED_MASK) == 16'h0000)
        else $error("unused bit set in answer");
    a_mask_readback: assert property (s_cmd(3) ##1 s_cmd(4) |=>
        resp_data_o == ($past(cmd_data_i, 2) & asrs_pkg::USED_MASK))
        else $error("mask readback wrong");
    a_preset_clears: assert property (s_cmd(5) ##1 s_cmd(4) |=> resp_data_o == 16'h0000)
        else $error("mask not cleared by preset");
    a_summary_preset: assert property (s_cmd(5) ##1 clk_en_i |=> !alarm_summary_o)
        else $error("summary high with empty mask");
    a_live_readonly: assert property (s_q(1) ##1 s_q(1) |=> $stable(resp_data_o))
        else $error("live state changed by query");
    a_events_clear: assert property (s_q(2) ##1 s_q(2) ##1 s_q(2) |=> !resp_data_o)
        else $error("latched events not cleared by query");
    c_mask_rw: cover property (s_cmd(3) ##1 s_cmd(4));
    c_summary: cover property (alarm_summary_o);
    c_events_q: cover property (s_q(2) ##1 s_q(2) ##1 s_q(2));
endmodule // asrs_checker

bind asrs_top asrs_checker asrs_checker_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .cmd_data_i(cmd_data_i), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
    .queue_push_i(queue_push_i), .queue_pop_i(queue_pop_i), .alarm_i(alarm_i),
    .lower_limit_i(lower_limit_i), .upper_limit_i(upper_limit_i),
    .alarm_summary_o(alarm_summary_o));

// [tb/tb_top.sv]
// Testbench of the alarm status register set
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic [2:0] cmd_code_i = 3'h0;
    logic [15:0] cmd_data_i = 16'h0000;
    logic queue_push_i = 1'b0;
    logic queue_pop_i = 1'b0;
    logic [3:0] alarm_i = 4'h0;
    logic lower_limit_i = 1'b0;
    logic upper_limit_i = 1'b0;
    logic resp_valid_o;
    logic [15:0] resp_data_o;
    logic queue_full_o;
    logic alarm_summary_o;
    int num_errors = 0;
    int checks = 0;
    logic [15:0] expq[$];
    int pos[6] = '{6, 7, 8, 9, 12, 13};
    asrs_top asrs_top_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i),
        .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .queue_push_i(queue_push_i),
        .queue_pop_i(queue_pop_i), .alarm_i(alarm_i), .lower_limit_i(lower_limit_i),
        .upper_limit_i(upper_limit_i), .queue_full_o(queue_full_o),
        .alarm_summary_o(alarm_summary_o));
    always #5 sys_clk_i = ~sys_clk_i;
    task automatic chk(string name, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask
    // Answers are matched in issue order; an answer nobody asked for is a mismatch
    always @(negedge sys_clk_i) begin
        if (resp_valid_o === 1'b1) begin
            if (expq.size() != 0) chk("resp_data", expq.pop_front(), resp_data_o);
            else chk("answer count", 16'h0000, 16'h0001);
        end
    end
    // Valid stays up between calls so commands can go back to back
    task automatic cmd(logic [2:0] c, logic [15:0] d = 16'h0000, logic [15:0] e = 16'h0000);
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'b1;
        cmd_code_i <= c;
        cmd_data_i <= d;
        if (c inside {3'h1, 3'h2, 3'h4}) expq.push_back(e);
    endtask
    task automatic idle(int n);
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'b0;
        queue_push_i <= 1'b0;
        queue_pop_i <= 1'b0;
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic src(logic [5:0] v);
        @(posedge sys_clk_i);
        {upper_limit_i, lower_limit_i, alarm_i} <= v;
        idle(3);
    endtask
    task automatic qop(logic p, int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            if (p) queue_push_i <= 1'b1;
            else queue_pop_i <= 1'b1;
        end
        idle(3);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        cmd(3'h4);
        cmd(3'h1);
        cmd(3'h2);
        cmd(3'h7);
        idle(2);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            src(6'h01 << i);
            cmd(3'h1, 16'h0000, 16'h0001 << pos[i]);
            cmd(3'h1, 16'h0000, 16'h0001 << pos[i]);
            idle(0);
            src(6'h00);
            cmd(3'h2, 16'h0000, 16'h0001 << pos[i]);
            cmd(3'h2);
            cmd(3'h2);
            idle(2);
        end
        $display("test sources done");
        qop(1'b1, asrs_pkg::QUEUE_DEPTH);
        cmd(3'h1, 16'h0000, 16'h0010);
        idle(1);
        chk("queue_full", 16'h0001, {15'h0000, queue_full_o});
        qop(1'b0, asrs_pkg::QUEUE_DEPTH - 1);
        chk("queue_full", 16'h0000, {15'h0000, queue_full_o});
        cmd(3'h1, 16'h0000, 16'h0010);
        cmd(3'h6);
        idle(3);
        cmd(3'h1);
        cmd(3'h2);
        idle(2);
        $display("test queue done");
        cmd(3'h3, 16'hffff);
        cmd(3'h4, 16'h0000, 16'h33d0);
        cmd(3'h3, 16'h0040);
        cmd(3'h4, 16'h0000, 16'h0040);
        idle(0);
        src(6'h02);
        chk("alarm_summary", 16'h0000, {15'h0000, alarm_summary_o});
        src(6'h03);
        chk("alarm_summary", 16'h0001, {15'h0000, alarm_summary_o});
        src(6'h00);
        cmd(3'h2, 16'h0000, 16'h00c0);
        idle(3);
        chk("alarm_summary", 16'h0000, {15'h0000, alarm_summary_o});
        cmd(3'h5);
        cmd(3'h4);
        idle(3);
        // A low clock enable must swallow the write, so the mask still reads zero
        clk_en_i <= 1'b0;
        cmd(3'h3, 16'h1000);
        idle(1);
        clk_en_i <= 1'b1;
        cmd(3'h4, 16'h0000, 16'h0000);
        idle(3);
        chk("pending answers", 16'h0000, 16'(expq.size()));
        $display("test mask done");
        final_report();
    end
endmodule // tb_top
